/* bench/vapr_aiding_source.sv */
// Purpose: Serial aiding source that sends 8N1 characters on rxd.
// Assumes: The bench calls send_byte; bit time follows the receiver clock.
// Notes: The line idles high between characters.
`timescale 1ns/100ps
`default_nettype none
`include "vapr_cfg.svh"
module vapr_aiding_source #(
    parameter int BIT_CYC = `VAPR_BIT_CYC
) (
    input wire logic clk,
    output logic rxd
);
    initial rxd = 1'b1;

    // Sends one character LSB first; a low stopBit makes a framing fault.
    task automatic send_byte(input logic [7:0] data, input logic stopBit);
        logic [9:0] frame;
        frame = {stopBit, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            rxd = frame[i];
            repeat (BIT_CYC - 1) @(negedge clk);
        end
        @(negedge clk);
        rxd = 1'b1;
    endtask
endmodule
`default_nettype wire

/* bench/vapr_receiver_tb.sv */
// Purpose: Self-checking bench for the velocity aiding packet receiver.
// Assumes: A 16-clock bit time, so a packet takes about 5200 cycles.
// Notes: The timeout is set to about one and a half packet times.
`timescale 1ns/100ps
`default_nettype none
`include "vapr_cfg.svh"
module vapr_receiver_tb;
    localparam int unsigned BIT_CYC = 16;
    localparam int unsigned TO_CYC = 8000;
    localparam int unsigned FREEZE = 100;
    localparam int OFF [10] = '{2, 6, 10, 14, 16, 18, 20, 22, 26, 28};
    localparam int WID [10] = '{4, 4, 4, 2, 2, 2, 2, 4, 2, 2};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic clkEn = 1'b1;
    wire logic rxd;
    logic [31:0] latitude, longitude, gnssAltitude, pressureAltitude;
    logic [15:0] groundSpeed, trueTrack, gnssVertSpeed, trueAirspeed;
    logic [15:0] baroVertSpeed, magVariation;
    logic [9:0] fieldValid;
    logic pktAccepted, pktRejected, frameError, aidingLost;
    logic [31:0] seen [10];
    logic [7:0] pkt [2][32];
    int mismatches = 0;
    int n_compared = 0;
    int accCnt = 0;
    int rejCnt = 0;
    int ferrCnt = 0;
    longint cyc = 0;
    longint accCyc = 0;
    longint lostCyc = 0;

    always #4 clk = ~clk;

    vapr_aiding_source #(.BIT_CYC(BIT_CYC)) src (.clk(clk), .rxd(rxd));

    vapr_receiver #(.TIMEOUT_CYC(TO_CYC), .BIT_CYCLES(BIT_CYC)) DUT (
        .clk(clk), .rstn(rstn), .clkEn(clkEn), .rxd(rxd),
        .latitude(latitude), .longitude(longitude),
        .gnssAltitude(gnssAltitude), .groundSpeed(groundSpeed),
        .trueTrack(trueTrack), .gnssVertSpeed(gnssVertSpeed),
        .trueAirspeed(trueAirspeed), .pressureAltitude(pressureAltitude),
        .baroVertSpeed(baroVertSpeed), .magVariation(magVariation),
        .fieldValid(fieldValid), .pktAccepted(pktAccepted),
        .pktRejected(pktRejected), .frameError(frameError),
        .aidingLost(aidingLost)
    );

    always_comb seen = '{latitude, longitude, gnssAltitude,
        32'(groundSpeed), 32'(trueTrack), 32'(gnssVertSpeed),
        32'(trueAirspeed), pressureAltitude, 32'(baroVertSpeed),
        32'(magVariation)};

    // Counts cycles each pulse is high, sampled where outputs have settled.
    always @(negedge clk) begin
        cyc <= cyc + 1;
        if (pktAccepted === 1'b1) begin
            accCnt++;
            accCyc = cyc;
        end
        if (pktRejected === 1'b1) rejCnt++;
        if (frameError === 1'b1) ferrCnt++;
        if (aidingLost === 1'b1 && accCnt > 0 && lostCyc == 0) lostCyc = cyc;
    end

    task automatic check(input string name, input logic [31:0] s,
                         input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic build(input int k, input logic [7:0] seed, input bit bad);
        int sum;
        sum = 0;
        pkt[k][0] = `VAPR_HDR0;
        pkt[k][1] = `VAPR_HDR1;
        for (int i = 2; i < 30; i++) begin
            pkt[k][i] = seed + 8'(i * 7);
            if (i < 6 || i == 16 || i == 17 || i > 27) pkt[k][i] = 8'hff;
            sum += pkt[k][i];
        end
        sum = sum % 65535 + (bad ? 1 : 0);
        pkt[k][30] = sum[15:8];
        pkt[k][31] = sum[7:0];
    endtask

    function automatic logic [31:0] field(input int k, input int f);
        logic [31:0] v;
        v = 32'h0;
        for (int b = 0; b < WID[f]; b++) v = {v[23:0], pkt[k][OFF[f] + b]};
        return v;
    endfunction

    task automatic send_pkt(input int k);
        for (int i = 0; i < 32; i++) src.send_byte(pkt[k][i], 1'b1);
    endtask

    task automatic check_fields(input int k);
        logic [31:0] ones;
        for (int f = 0; f < 10; f++) begin
            ones = (WID[f] == 4) ? `VAPR_ALL1_32 : {16'h0, `VAPR_ALL1_16};
            check("field", seen[f], field(k, f));
            check("valid", fieldValid[f], field(k, f) !== ones);
        end
    endtask

    task automatic test_reset();
        check("lostAtReset", aidingLost, 1);
        check("validAtReset", fieldValid, 0);
    endtask

    // Noise, then a repeated first header byte, before a good packet.
    task automatic test_good();
        build(0, 8'h13, 0);
        src.send_byte(8'h12, 1'b1);
        src.send_byte(`VAPR_HDR0, 1'b1);
        send_pkt(0);
        check("accepted", accCnt, 1);
        check("rejected", rejCnt, 0);
        check_fields(0);
        check("lostAfterGood", aidingLost, 0);
    endtask

    task automatic test_bad();
        build(1, 8'h41, 1);
        send_pkt(1);
        check("rejectedBad", rejCnt, 1);
        check("acceptedBad", accCnt, 1);
        check_fields(0);
    endtask

    task automatic test_frame();
        src.send_byte(`VAPR_HDR0, 1'b0);
        check("frameErr", ferrCnt, 1);
        check("lostEarly", aidingLost, 0);
    endtask

    // A frozen stretch of clkEn must delay the loss by its length, within one cycle.
    task automatic test_loss();
        clkEn = 1'b0;
        repeat (FREEZE) @(negedge clk);
        clkEn = 1'b1;
        repeat (TO_CYC) begin
            if (lostCyc != 0) break;
            @(posedge clk);
        end
        check("lossTime", (lostCyc - accCyc >= TO_CYC + FREEZE - 1) &&
              (lostCyc - accCyc <= TO_CYC + FREEZE + 1), 1);
    endtask

    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        test_reset();
        test_good();
        test_bad();
        test_frame();
        test_loss();
        print_verdict();
    end
endmodule
`default_nettype wire

/* rtl/vapr_cfg.svh */
// Purpose: Constants for the velocity aiding packet receiver.
// Assumes: 125 MHz system clock, 9600 baud 8N1 serial aiding input.
// Notes: Field byte positions count from the first header byte.
//
// Functional notes
// - Serial link is asynchronous 9600 baud, 8 data bits, no parity, 1 stop.
// - Packets start with header bytes 0xaa then 0x55, used for alignment.
// - Checksum is the content sum modulo 0xffff, compared with received.
// - Checksum covers bytes 2 to 29 and sits in bytes 30 and 31.
// - Bytes 2 to 5 hold signed latitude; all ones means invalid.
// - Bytes 6 to 9 hold signed longitude; all ones means invalid.
// - Bytes 10 to 13 hold GNSS altitude; all ones means invalid.
// - Bytes 14 to 15 hold ground speed; 0xffff means invalid.
// - Bytes 16 to 17 hold true track; 0xffff means invalid.
// - Bytes 18 to 19 hold GNSS vertical velocity; 0xffff means invalid.
// - Bytes 20 to 21 hold true airspeed; 0xffff means invalid.
// - Bytes 22 to 25 hold pressure altitude; all ones means invalid.
// - Bytes 26 to 27 hold barometric vertical velocity; 0xffff invalid.
// - Bytes 28 to 29 hold magnetic variation; 0xffff means invalid.
// - Multi-byte values are two's complement, most significant byte first.
// - Missing or failing packets raise loss of aiding for unaided fallback.
`ifndef VAPR_CFG_SVH
`define VAPR_CFG_SVH
`define VAPR_CLK_HZ 125000000
`define VAPR_BAUD 9600
`define VAPR_BIT_CYC (`VAPR_CLK_HZ / `VAPR_BAUD)
`define VAPR_HALF_CYC (`VAPR_BIT_CYC / 2)
`define VAPR_HDR0 8'haa
`define VAPR_HDR1 8'h55
`define VAPR_PKT_LEN 6'h20
`define VAPR_LAST_IDX 6'h1f
`define VAPR_SUM_FIRST 6'h02
`define VAPR_SUM_LAST 6'h1d
`define VAPR_CSUM_MOD 17'h0ffff
`define VAPR_TIMEOUT_S 3
`define VAPR_NFIELD 10
`define VAPR_ALL1_32 32'hffffffff
`define VAPR_ALL1_16 16'hffff
`endif

/* rtl/vapr_pkg.sv */
// Purpose: Types for the velocity aiding packet receiver.
// Assumes: Nothing beyond the constants header.
// Notes: One-hot state codes.
package vapr_pkg;
    typedef enum logic [3:0] {
        VAPR_IDLE = 4'h1,
        VAPR_START = 4'h2,
        VAPR_DATA = 4'h4,
        VAPR_STOP = 4'h8
    } vapr_rx_t;
endpackage

/* rtl/vapr_receiver.sv */
// Purpose: Serial receiver and parser for external velocity aiding packets.
// Assumes: rxd is synchronous to clk and idles high.
// Notes: Field outputs change only on an accepted packet.
`timescale 1ns/100ps
`default_nettype none
`include "vapr_cfg.svh"
module vapr_receiver #(
    parameter int unsigned TIMEOUT_CYC = `VAPR_TIMEOUT_S * `VAPR_CLK_HZ,
    parameter int unsigned BIT_CYCLES = `VAPR_BIT_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic rxd,
    output logic [31:0] latitude,
    output logic [31:0] longitude,
    output logic [31:0] gnssAltitude,
    output logic [15:0] groundSpeed,
    output logic [15:0] trueTrack,
    output logic [15:0] gnssVertSpeed,
    output logic [15:0] trueAirspeed,
    output logic [31:0] pressureAltitude,
    output logic [15:0] baroVertSpeed,
    output logic [15:0] magVariation,
    output logic [9:0] fieldValid,
    output logic pktAccepted,
    output logic pktRejected,
    output logic frameError,
    output logic aidingLost
);
    // ------------------------------------------------------------
    // Character receiver
    // ------------------------------------------------------------
    // Bit time is a parameter so that a short simulation can scale it down.
    localparam logic [13:0] BIT_CYC = 14'(BIT_CYCLES);
    localparam logic [13:0] HALF_CYC = 14'(BIT_CYCLES / 2);
    vapr_pkg::vapr_rx_t rxState;
    vapr_pkg::vapr_rx_t next_rxState;
    logic [13:0] baudCnt;
    logic [2:0] bitIdx;
    logic [7:0] shiftReg;
    logic rxdPrev;
    wire baudDone = (baudCnt == 14'h0);
    wire startEdge = rxdPrev && !rxd;
    wire byteDone = (rxState == vapr_pkg::VAPR_STOP) && baudDone && rxd;
    wire byteBad = (rxState == vapr_pkg::VAPR_STOP) && baudDone && !rxd;
    wire [7:0] rxByte = shiftReg;

    always_comb begin
        next_rxState = rxState;
        case (rxState)
            vapr_pkg::VAPR_IDLE: begin
                if (startEdge) begin
                    next_rxState = vapr_pkg::VAPR_START;
                end
            end
            vapr_pkg::VAPR_START: begin
                if (baudDone) begin
                    next_rxState = rxd ? vapr_pkg::VAPR_IDLE
                                       : vapr_pkg::VAPR_DATA;
                end
            end
            vapr_pkg::VAPR_DATA: begin
                if (baudDone && bitIdx == 3'h7) begin
                    next_rxState = vapr_pkg::VAPR_STOP;
                end
            end
            vapr_pkg::VAPR_STOP: begin
                if (baudDone) begin
                    next_rxState = vapr_pkg::VAPR_IDLE;
                end
            end
            default: next_rxState = vapr_pkg::VAPR_IDLE;
        endcase
    end

    // Samples each bit at its centre; 8N1 with one stop bit.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxState <= vapr_pkg::VAPR_IDLE;
            baudCnt <= 14'h0;
            bitIdx <= 3'h0;
            shiftReg <= 8'h0;
            rxdPrev <= 1'b1;
        end else if (clkEn) begin
            rxState <= next_rxState;
            rxdPrev <= rxd;
            if (rxState == vapr_pkg::VAPR_IDLE) begin
                baudCnt <= HALF_CYC;
                bitIdx <= 3'h0;
            end else if (baudDone) begin
                baudCnt <= BIT_CYC - 14'h1;
                if (rxState == vapr_pkg::VAPR_DATA) begin
                    shiftReg <= {rxd, shiftReg[7:1]};
                    bitIdx <= bitIdx + 3'h1;
                end
            end else begin
                baudCnt <= baudCnt - 14'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Packet framing and checksum
    // ------------------------------------------------------------
    logic [5:0] byteIdx;
    logic [16:0] sumAcc;
    logic [15:0] rxCsum;
    logic [7:0] pkt [0:29];
    wire inSum = (byteIdx >= `VAPR_SUM_FIRST) && (byteIdx <= `VAPR_SUM_LAST);
    wire [16:0] sumAdd = sumAcc + {9'h0, rxByte};
    // Fold keeps the running sum reduced modulo 0xffff.
    wire [16:0] sumNext = (sumAdd >= `VAPR_CSUM_MOD) ?
                          sumAdd - `VAPR_CSUM_MOD : sumAdd;
    wire lastByte = byteDone && (byteIdx == `VAPR_LAST_IDX);
    wire csumOk = (sumAcc[15:0] == {rxCsum[7:0], rxByte});
    wire hdrMiss0 = (byteIdx == 6'h0) && (rxByte != `VAPR_HDR0);
    wire hdrMiss1 = (byteIdx == 6'h1) && (rxByte != `VAPR_HDR1);
    wire goodPkt = lastByte && csumOk;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            byteIdx <= 6'h0;
            sumAcc <= 17'h0;
            rxCsum <= 16'h0;
        end else if (clkEn) begin
            if (byteBad) begin
                byteIdx <= 6'h0;
            end else if (byteDone) begin
                if (hdrMiss0) begin
                    byteIdx <= 6'h0;
                end else if (hdrMiss1) begin
                    byteIdx <= (rxByte == `VAPR_HDR0) ? 6'h1 : 6'h0;
                end else if (lastByte) begin
                    byteIdx <= 6'h0;
                end else begin
                    byteIdx <= byteIdx + 6'h1;
                end
                if (byteIdx == 6'h1) begin
                    sumAcc <= 17'h0;
                end else if (inSum) begin
                    sumAcc <= sumNext;
                end
                rxCsum <= {rxCsum[7:0], rxByte};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (clkEn && byteDone && inSum) begin
            pkt[byteIdx[4:0]] <= rxByte;
        end
    end

    // ------------------------------------------------------------
    // Field extraction, most significant byte first
    // ------------------------------------------------------------
    wire [31:0] fLat = {pkt[2], pkt[3], pkt[4], pkt[5]};
    wire [31:0] fLon = {pkt[6], pkt[7], pkt[8], pkt[9]};
    wire [31:0] fAlt = {pkt[10], pkt[11], pkt[12], pkt[13]};
    wire [15:0] fGs = {pkt[14], pkt[15]};
    wire [15:0] fTrk = {pkt[16], pkt[17]};
    wire [15:0] fGvv = {pkt[18], pkt[19]};
    wire [15:0] fTas = {pkt[20], pkt[21]};
    wire [31:0] fPalt = {pkt[22], pkt[23], pkt[24], pkt[25]};
    wire [15:0] fBvv = {pkt[26], pkt[27]};
    wire [15:0] fMv = {pkt[28], pkt[29]};
    wire [9:0] next_valid = {
        fMv != `VAPR_ALL1_16, fBvv != `VAPR_ALL1_16,
        fPalt != `VAPR_ALL1_32, fTas != `VAPR_ALL1_16,
        fGvv != `VAPR_ALL1_16, fTrk != `VAPR_ALL1_16,
        fGs != `VAPR_ALL1_16, fAlt != `VAPR_ALL1_32,
        fLon != `VAPR_ALL1_32, fLat != `VAPR_ALL1_32};

    // Field and valid outputs move only on a good checksum.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latitude <= 32'h0;
            longitude <= 32'h0;
            gnssAltitude <= 32'h0;
            groundSpeed <= 16'h0;
            trueTrack <= 16'h0;
            gnssVertSpeed <= 16'h0;
            trueAirspeed <= 16'h0;
            pressureAltitude <= 32'h0;
            baroVertSpeed <= 16'h0;
            magVariation <= 16'h0;
            fieldValid <= 10'h0;
            pktAccepted <= 1'b0;
            pktRejected <= 1'b0;
            frameError <= 1'b0;
        end else if (clkEn) begin
            pktAccepted <= goodPkt;
            pktRejected <= lastByte && !csumOk;
            frameError <= byteBad;
            if (goodPkt) begin
                latitude <= fLat;
                longitude <= fLon;
                gnssAltitude <= fAlt;
                groundSpeed <= fGs;
                trueTrack <= fTrk;
                gnssVertSpeed <= fGvv;
                trueAirspeed <= fTas;
                pressureAltitude <= fPalt;
                baroVertSpeed <= fBvv;
                magVariation <= fMv;
                fieldValid <= next_valid;
            end
        end
    end

    // ------------------------------------------------------------
    // Aiding loss watchdog
    // ------------------------------------------------------------
    logic [31:0] idleCnt;
    wire timedOut = (idleCnt >= TIMEOUT_CYC - 1);

    // Sources send once per second, so several missed periods means lost.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idleCnt <= 32'h0;
            aidingLost <= 1'b1;
        end else if (clkEn) begin
            if (goodPkt) begin
                idleCnt <= 32'h0;
                aidingLost <= 1'b0;
            end else if (timedOut) begin
                aidingLost <= 1'b1;
            end else begin
                idleCnt <= idleCnt + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Every property runs on the system clock and sleeps during reset.
    a_reject_holds: assert property (
        @(posedge clk) disable iff (!rstn)
        pktRejected |-> $stable(latitude) && $stable(fieldValid))
        else $error("rejected packet changed outputs");
    a_accept_pulse: assert property (
        @(posedge clk) disable iff (!rstn)
        pktAccepted && clkEn |=> !pktAccepted)
        else $error("accept strobe longer than one cycle");
    a_accept_clears_lost: assert property (
        @(posedge clk) disable iff (!rstn)
        pktAccepted |-> !aidingLost)
        else $error("aiding lost set after accepted packet");
    a_valid_lat: assert property (
        @(posedge clk) disable iff (!rstn)
        pktAccepted |-> fieldValid[0] == (latitude != `VAPR_ALL1_32))
        else $error("latitude valid flag wrong");
    a_valid_gs: assert property (
        @(posedge clk) disable iff (!rstn)
        pktAccepted |-> fieldValid[3] == (groundSpeed != `VAPR_ALL1_16))
        else $error("ground speed valid flag wrong");
    a_valid_mv: assert property (
        @(posedge clk) disable iff (!rstn)
        pktAccepted |-> fieldValid[9] == (magVariation != `VAPR_ALL1_16))
        else $error("magnetic variation valid flag wrong");
    a_timeout_lost: assert property (
        @(posedge clk) disable iff (!rstn)
        clkEn && timedOut && !goodPkt |=> aidingLost)
        else $error("timeout did not raise aiding lost");
    a_header_first: assert property (
        @(posedge clk) disable iff (!rstn)
        clkEn && byteDone && hdrMiss0 |=> byteIdx == 6'h0)
        else $error("header search advanced on wrong byte");
    a_sum_reduced: assert property (
        @(posedge clk) disable iff (!rstn)
        sumAcc < `VAPR_CSUM_MOD)
        else $error("checksum accumulator out of range");
    a_strobes_exclusive: assert property (
        @(posedge clk) disable iff (!rstn)
        !(pktAccepted && pktRejected))
        else $error("accept and reject strobes together");
    a_fields_hold: assert property (
        @(posedge clk) disable iff (!rstn)
        !pktAccepted |-> $stable(latitude) && $stable(fieldValid) &&
            $stable(magVariation) && $stable(pressureAltitude))
        else $error("fields changed without an accepted packet");
    a_frame_restart: assert property (
        @(posedge clk) disable iff (!rstn)
        clkEn && byteBad |=> byteIdx == 6'h0)
        else $error("framing fault did not restart header search");
    a_lost_holds: assert property (
        @(posedge clk) disable iff (!rstn)
        clkEn && aidingLost && !goodPkt |=> aidingLost)
        else $error("aiding lost cleared without a good packet");
    a_header_second: assert property (
        @(posedge clk) disable iff (!rstn)
        clkEn && byteDone && hdrMiss1 |=> byteIdx <= 6'h1)
        else $error("second header byte mismatch advanced search");
    a_accept_valid: assert property (
        @(posedge clk) disable iff (!rstn)
        clkEn && goodPkt |=> pktAccepted && fieldValid == $past(next_valid))
        else $error("accepted packet valid flags wrong");
    a_reject_strobe: assert property (
        @(posedge clk) disable iff (!rstn)
        clkEn && lastByte && !csumOk |=> pktRejected && !pktAccepted)
        else $error("bad checksum not rejected");
endmodule
`default_nettype wire
